// ### rtl/byte_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ns
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Filling side.
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Draining side.
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_type;
   fifo_state_type s_r, s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // Full when pointers differ only in the wrap bit.
   assign in_ready_o = (s_r.wr ^ s_r.rd) != {1'b1, {AW{1'b0}}};
   assign out_valid_o = s_r.wr != s_r.rd;
   assign out_data_o = mem[s_r.rd[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer update.
   always_comb begin
      s_nxt = s_r;
      if (push) s_nxt.wr = s_r.wr + 1'b1;
      if (pop) s_nxt.rd = s_r.rd + 1'b1;
   end

   // Storage is not reset; only the pointers decide what is valid.
   always_ff @(posedge clock_i) begin
      if (push) mem[s_r.wr[AW-1:0]] <= in_data_i;
      if (srst_i) s_r <= '0;
      else s_r <= s_nxt;
   end
endmodule // byte_fifo

// ### rtl/tag_cmd_device.sv
// Device end: executes block read and write commands received over the link.
// Overview of operation
// R1 - Opcode 0x86 plus block reads 16 bytes.
// R2 - Unauthenticated block commands fail.
// R3 - Read success: length 0x12, opcode, block, data.
// R4 - Read failure: length 0x02, opcode, N or F.
// R5 - Page tags: four consecutive pages fill read.
// R6 - Opcode 0x87 reads a 4-byte signed value.
// R7 - Bad value format gives error 0x49.
// R8 - Value success: length 0x06, value LSB first.
// R9 - Value read failure: length 0x02, N/I/F.
// R10 - Opcode 0x89 carries block and 16 bytes.
// R11 - Writes are read back; mismatch gives 0x55.
// R12 - Unreadable read-back gives error 0x58.
// R13 - Verified block write echoes read-back data.
// R14 - Block write failure: opcode plus U/X/N/F.
// R15 - Key A trailer writes report mismatch.
// R16 - Opcode 0x8A value; device formats block.
// R17 - Value write answers read-back value.
// R18 - Value write failure: length 0x02, N/I/F.
// R19 - Opcode 0x8B writes four page bytes.
// R20 - Page write: 0x06 success, 0x01 failure.
// R21 - Host reselects tag after failed authentication.
// R22 - Frames: FF 00, length, opcode, payload, checksum.
// R23 - Host awaits full response before next command.
`timescale 1ns/1ns
module tag_cmd_device
   import tag_cmd_pkg::*;
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Link to the host.
   tag_link_if.dev link,
   // Authentication state from the session logic.
   input wire logic auth_valid_i,
   input wire logic [7:0] auth_blk_i,
   input wire logic page_tag_i,
   // Tag access port.
   output logic tag_req_o,
   output logic tag_we_o,
   output logic [7:0] tag_blk_o,
   output logic [127:0] tag_wdata_o,
   input wire logic tag_ack_i,
   input wire logic [127:0] tag_rdata_i,
   input wire logic tag_absent_i,
   input wire logic tag_fail_i
);
   // ***************************************************************
   // State.
   // ***************************************************************
   typedef enum logic [8:0] {
      ST_HUNT = 9'h001,
      ST_SYNC = 9'h002,
      ST_LEN = 9'h004,
      ST_OP = 9'h008,
      ST_BODY = 9'h010,
      ST_CHK = 9'h020,
      ST_EXEC = 9'h040,
      ST_WAIT = 9'h080,
      ST_RESP = 9'h100
   } dev_state_type;

   typedef struct packed {
      dev_state_type st;
      logic [7:0] len;
      logic [7:0] op;
      logic [7:0] blk;
      logic [7:0] cnt;
      logic [7:0] sum;
      logic [7:0] err;
      logic failed;
      logic vfy;
      logic [1:0] page;
      logic req;
      logic we;
      logic [7:0] tblk;
      logic [127:0] wbuf;
      logic [127:0] rbuf;
   } dev_regs_type;

   dev_regs_type s_r, s_nxt;
   logic fifo_ready, fifo_push;
   logic [7:0] tx_byte, nbody, rsp_len;

   // ***************************************************************
   // Response byte selection.
   // ***************************************************************
   // Error frames carry only the code after the opcode.
   assign nbody = s_r.failed ? BODY_ERR : ok_body(s_r.op);
   assign rsp_len = !s_r.failed ? ((ok_body(s_r.op) == BODY_LONG) ? LEN_BLOCK : LEN_VALUE) :
                    (s_r.op inside {OP_WR_BLOCK, OP_WR_PAGE}) ? LEN_ERR_WR :
                    LEN_ERR; // see R14 see R20

   // Frame assembly: sync, length, opcode, payload, checksum.
   always_comb begin
      logic [7:0] k;
      k = s_r.cnt - HDR_BYTES;
      if (s_r.cnt == 8'h00) tx_byte = SYNC0; // see R22
      else if (s_r.cnt == 8'h01) tx_byte = SYNC1;
      else if (s_r.cnt == 8'h02) tx_byte = rsp_len;
      else if (s_r.cnt == 8'h03) tx_byte = s_r.op;
      else if (k == nbody) tx_byte = s_r.sum;
      else if (s_r.failed) tx_byte = s_r.err;
      else if (k == 8'h00) tx_byte = s_r.blk; // see R3 see R8
      else tx_byte = s_r.rbuf[8*(k-8'h01) +: 8]; // see R13 see R17
   end

   assign fifo_push = s_r.st == ST_RESP;
   assign link.h2d_ready = !(s_r.st inside {ST_EXEC, ST_WAIT, ST_RESP});
   assign tag_req_o = s_r.req;
   assign tag_we_o = s_r.we;
   assign tag_blk_o = s_r.tblk;
   assign tag_wdata_o = s_r.wbuf;

   // ***************************************************************
   // Command sequencer.
   // ***************************************************************
   always_comb begin
      logic rx;
      logic [7:0] d;
      rx = link.h2d_valid && link.h2d_ready;
      d = link.h2d_data;
      s_nxt = s_r;
      unique case (s_r.st)
         ST_HUNT: if (rx && d == SYNC0) s_nxt.st = ST_SYNC;
         ST_SYNC: if (rx) s_nxt.st = (d == SYNC1) ? ST_LEN : ST_HUNT;
         ST_LEN: if (rx) begin
            s_nxt.len = d;
            s_nxt.sum = d;
            s_nxt.st = ST_OP;
         end
         ST_OP: if (rx) begin
            s_nxt.op = d;
            s_nxt.sum = s_r.sum + d;
            s_nxt.cnt = 8'h00;
            s_nxt.st = (s_r.len > 8'h01) ? ST_BODY : ST_CHK;
         end
         ST_BODY: if (rx) begin
            // First body byte is the block number, the rest is write data.
            if (s_r.cnt == 8'h00) s_nxt.blk = d;
            else if (s_r.cnt <= BODY_LONG - 8'h01) s_nxt.wbuf[8*(s_r.cnt-8'h01) +: 8] = d;
            s_nxt.sum = s_r.sum + d;
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == s_r.len - 8'h02) s_nxt.st = ST_CHK;
         end
         ST_CHK: if (rx) begin
            // Bad checksum, unknown opcode or wrong length drops the frame silently.
            s_nxt.st = ST_HUNT;
            if (d == s_r.sum) begin // see R22
               unique case (s_r.op)
                  OP_RD_BLOCK, OP_RD_VALUE: if (s_r.len == LEN_RD_CMD) s_nxt.st = ST_EXEC; // see R1 see R6
                  OP_WR_BLOCK: if (s_r.len == LEN_BLOCK) s_nxt.st = ST_EXEC; // see R10
                  OP_WR_VALUE, OP_WR_PAGE: if (s_r.len == LEN_VALUE) s_nxt.st = ST_EXEC; // see R16 see R19
                  default: s_nxt.st = ST_HUNT;
               endcase
            end
         end
         ST_EXEC: begin
            s_nxt.failed = 1'b0;
            s_nxt.vfy = 1'b0;
            s_nxt.page = 2'h0;
            s_nxt.tblk = s_r.blk;
            s_nxt.cnt = 8'h00;
            s_nxt.sum = 8'h00;
            if (!(auth_valid_i && auth_blk_i == s_r.blk) && s_r.op != OP_WR_PAGE) begin
               s_nxt.failed = 1'b1; // see R2
               s_nxt.err = ERR_FAIL;
               s_nxt.st = ST_RESP;
            end else begin
               s_nxt.req = 1'b1;
               s_nxt.we = s_r.op inside {OP_WR_BLOCK, OP_WR_VALUE, OP_WR_PAGE};
               if (s_r.op == OP_WR_VALUE) // see R16
                  s_nxt.wbuf = {~s_r.blk, s_r.blk, ~s_r.blk, s_r.blk,
                                s_r.wbuf[31:0], ~s_r.wbuf[31:0], s_r.wbuf[31:0]};
               s_nxt.st = ST_WAIT;
            end
         end
         ST_WAIT: if (tag_ack_i) begin
            s_nxt.req = 1'b0;
            s_nxt.st = ST_RESP;
            if (tag_absent_i) begin
               s_nxt.failed = 1'b1; // see R4 see R9 see R14 see R18
               s_nxt.err = ERR_NO_TAG;
            end else if (s_r.we) begin
               if (tag_fail_i) begin
                  s_nxt.failed = 1'b1;
                  s_nxt.err = ERR_FAIL;
               end else begin
                  // Every write that the tag accepts is followed by a read-back of the same block.
                  s_nxt.req = 1'b1; // see R11
                  s_nxt.we = 1'b0;
                  s_nxt.vfy = 1'b1;
                  s_nxt.st = ST_WAIT;
               end
            end else if (tag_fail_i) begin
               s_nxt.failed = 1'b1;
               s_nxt.err = (s_r.vfy && s_r.op != OP_WR_VALUE) ? ERR_NO_READ : ERR_FAIL; // see R12
            end else begin
               unique case (s_r.op)
                  OP_RD_VALUE, OP_WR_VALUE: begin
                     s_nxt.rbuf[31:0] = tag_rdata_i[31:0];
                     if (!value_ok(tag_rdata_i)) begin
                        s_nxt.failed = 1'b1; // see R7 see R18
                        s_nxt.err = ERR_VALUE;
                     end
                  end
                  OP_WR_BLOCK: begin
                     s_nxt.rbuf = tag_rdata_i;
                     // A key field that reads as zero cannot match what was written.
                     if (tag_rdata_i != s_r.wbuf) begin
                        s_nxt.failed = 1'b1; // see R11 see R15
                        s_nxt.err = ERR_MISMATCH;
                     end
                  end
                  OP_WR_PAGE: begin
                     s_nxt.rbuf[31:0] = tag_rdata_i[31:0];
                     if (tag_rdata_i[31:0] != s_r.wbuf[31:0]) begin
                        s_nxt.failed = 1'b1; // see R11
                        s_nxt.err = ERR_MISMATCH;
                     end
                  end
                  default: begin
                     if (!page_tag_i) begin
                        s_nxt.rbuf = tag_rdata_i; // see R1
                     end else begin
                        // Page tags: gather four bytes from this page and each of the next three.
                        s_nxt.rbuf[32*s_r.page +: 32] = tag_rdata_i[31:0]; // see R5
                        if (s_r.page != LAST_PAGE) begin
                           s_nxt.page = s_r.page + 2'h1;
                           s_nxt.tblk = s_r.tblk + 8'h01;
                           s_nxt.req = 1'b1;
                           s_nxt.st = ST_WAIT;
                        end
                     end
                  end
               endcase
            end
         end
         ST_RESP: if (fifo_ready) begin
            // Checksum runs over length, opcode and payload.
            if (s_r.cnt >= 8'h02) s_nxt.sum = s_r.sum + tx_byte;
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == nbody + HDR_BYTES) s_nxt.st = ST_HUNT;
         end
         default: s_nxt.st = ST_HUNT;
      endcase
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (srst_i) s_r <= '{st: ST_HUNT, default: '0};
      else s_r <= s_nxt;
   end

   // Responses queue here so a slow host stalls the sequencer, not the tag.
   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_valid_i(fifo_push),
      .in_data_i(tx_byte),
      .in_ready_o(fifo_ready),
      .out_valid_o(link.d2h_valid),
      .out_data_o(link.d2h_data),
      .out_ready_i(link.d2h_ready)
   );
endmodule // tag_cmd_device

// ### rtl/tag_cmd_host.sv
// Host end: frames one command at a time and decodes the response frame.
`timescale 1ns/1ns
module tag_cmd_host
   import tag_cmd_pkg::*;
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Link to the device.
   tag_link_if.host link,
   // Command request.
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_op_i,
   input wire logic [7:0] cmd_blk_i,
   input wire logic [127:0] cmd_data_i,
   output logic cmd_ready_o,
   // Response.
   output logic rsp_valid_o,
   output logic rsp_err_o,
   output logic rsp_chk_bad_o,
   output logic [7:0] rsp_op_o,
   output logic [7:0] rsp_code_o,
   output logic [127:0] rsp_data_o
);
   // ***************************************************************
   // State.
   // ***************************************************************
   typedef enum logic [6:0] {
      HS_IDLE = 7'h01,
      HS_SEND = 7'h02,
      HS_SYNC0 = 7'h04,
      HS_SYNC1 = 7'h08,
      HS_LEN = 7'h10,
      HS_BODY = 7'h20,
      HS_CHK = 7'h40
   } host_state_type;

   typedef struct packed {
      host_state_type st;
      logic [7:0] op;
      logic [7:0] blk;
      logic [7:0] len;
      logic [7:0] cnt;
      logic [7:0] sum;
      logic [127:0] data;
      logic done;
      logic err;
      logic chk_bad;
      logic [7:0] code;
   } host_regs_type;

   host_regs_type s_r, s_nxt;
   logic [7:0] tx_byte, clen, nbody, k;

   // Command length: opcode, block and the write data.
   assign clen = (s_r.op == OP_WR_BLOCK) ? LEN_BLOCK :
                 (s_r.op == OP_WR_VALUE || s_r.op == OP_WR_PAGE) ? LEN_VALUE : LEN_RD_CMD;
   assign k = s_r.cnt - HDR_BYTES;
   assign nbody = clen - 8'h01;

   // Command frame assembly.
   always_comb begin
      if (s_r.cnt == 8'h00) tx_byte = SYNC0; // see R22
      else if (s_r.cnt == 8'h01) tx_byte = SYNC1;
      else if (s_r.cnt == 8'h02) tx_byte = clen;
      else if (s_r.cnt == 8'h03) tx_byte = s_r.op;
      else if (k == nbody) tx_byte = s_r.sum;
      else if (k == 8'h00) tx_byte = s_r.blk; // see R1 see R6
      else tx_byte = s_r.data[8*(k-8'h01) +: 8]; // see R10 see R16 see R19
   end

   // Only one command in flight.
   assign cmd_ready_o = s_r.st == HS_IDLE; // see R23
   assign link.h2d_valid = s_r.st == HS_SEND;
   assign link.h2d_data = tx_byte;
   assign link.d2h_ready = !(s_r.st inside {HS_IDLE, HS_SEND});
   assign rsp_valid_o = s_r.done;
   assign rsp_err_o = s_r.err;
   assign rsp_chk_bad_o = s_r.chk_bad;
   assign rsp_op_o = s_r.op;
   assign rsp_code_o = s_r.code;
   assign rsp_data_o = s_r.data;

   // ***************************************************************
   // Command and response sequencer.
   // ***************************************************************
   always_comb begin
      logic rx;
      logic [7:0] d;
      rx = link.d2h_valid && link.d2h_ready;
      d = link.d2h_data;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      unique case (s_r.st)
         HS_IDLE: if (cmd_valid_i) begin
            s_nxt.op = cmd_op_i;
            s_nxt.blk = cmd_blk_i;
            s_nxt.data = cmd_data_i;
            s_nxt.cnt = 8'h00;
            s_nxt.sum = 8'h00;
            s_nxt.st = HS_SEND;
         end
         HS_SEND: if (link.h2d_ready) begin
            if (s_r.cnt >= 8'h02) s_nxt.sum = s_r.sum + tx_byte;
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (k == nbody) begin
               s_nxt.data = '0;
               s_nxt.st = HS_SYNC0;
            end
         end
         HS_SYNC0: if (rx && d == SYNC0) s_nxt.st = HS_SYNC1;
         HS_SYNC1: if (rx) s_nxt.st = (d == SYNC1) ? HS_LEN : HS_SYNC0;
         HS_LEN: if (rx) begin
            // Any length up to 0x02 is an error frame: opcode and code.
            s_nxt.len = (d <= LEN_ERR) ? LEN_ERR : d; // see R14
            s_nxt.err = d <= LEN_ERR;
            s_nxt.sum = d;
            s_nxt.cnt = 8'h00;
            s_nxt.st = HS_BODY;
         end
         HS_BODY: if (rx) begin
            if (s_r.cnt == 8'h00) s_nxt.op = d;
            else if (s_r.cnt == 8'h01) s_nxt.code = d;
            else if (s_r.cnt <= BODY_LONG) s_nxt.data[8*(s_r.cnt-8'h02) +: 8] = d;
            s_nxt.sum = s_r.sum + d;
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == s_r.len - 8'h01) s_nxt.st = HS_CHK;
         end
         HS_CHK: if (rx) begin
            s_nxt.chk_bad = d != s_r.sum; // see R22
            s_nxt.done = 1'b1;
            s_nxt.st = HS_IDLE;
         end
         default: s_nxt.st = HS_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (srst_i) s_r <= '{st: HS_IDLE, default: '0};
      else s_r <= s_nxt;
   end
endmodule // tag_cmd_host

// ### rtl/tag_cmd_pkg.sv
// Constants shared by both ends of the tag command link, and device helper functions.
package tag_cmd_pkg;
   // ***************************************************************
   // Framing bytes.
   // ***************************************************************
   localparam logic [7:0] SYNC0 = 8'hff;
   localparam logic [7:0] SYNC1 = 8'h00;
   // ***************************************************************
   // Opcodes.
   // ***************************************************************
   localparam logic [7:0] OP_RD_BLOCK = 8'h86;
   localparam logic [7:0] OP_RD_VALUE = 8'h87;
   localparam logic [7:0] OP_WR_BLOCK = 8'h89;
   localparam logic [7:0] OP_WR_VALUE = 8'h8a;
   localparam logic [7:0] OP_WR_PAGE = 8'h8b;
   // ***************************************************************
   // Length bytes.
   // ***************************************************************
   localparam logic [7:0] LEN_BLOCK = 8'h12;
   localparam logic [7:0] LEN_VALUE = 8'h06;
   localparam logic [7:0] LEN_ERR = 8'h02;
   localparam logic [7:0] LEN_ERR_WR = 8'h01;
   localparam logic [7:0] LEN_RD_CMD = 8'h02;
   // ***************************************************************
   // Error codes.
   // ***************************************************************
   localparam logic [7:0] ERR_NO_TAG = 8'h4e;
   localparam logic [7:0] ERR_FAIL = 8'h46;
   localparam logic [7:0] ERR_VALUE = 8'h49;
   localparam logic [7:0] ERR_MISMATCH = 8'h55;
   localparam logic [7:0] ERR_NO_READ = 8'h58;
   // ***************************************************************
   // Sizes and counts.
   // ***************************************************************
   localparam logic [7:0] BODY_LONG = 8'h11;
   localparam logic [7:0] BODY_SHORT = 8'h05;
   localparam logic [7:0] BODY_ERR = 8'h01;
   localparam logic [7:0] HDR_BYTES = 8'h04;
   localparam logic [1:0] LAST_PAGE = 2'h3;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;

   // Payload byte count after the opcode for a successful answer.
   function automatic logic [7:0] ok_body(input logic [7:0] op);
      return (op == OP_RD_BLOCK || op == OP_WR_BLOCK) ? BODY_LONG : BODY_SHORT;
   endfunction

   // Checks the redundant value-block layout.
   function automatic logic value_ok(input logic [127:0] d);
      return (d[63:32] == ~d[31:0]) && (d[95:64] == d[31:0]) &&
             (d[111:104] == ~d[103:96]) && (d[119:112] == d[103:96]) &&
             (d[127:120] == ~d[103:96]);
   endfunction
endpackage

// ### rtl/tag_link_if.sv
// Byte-stream link between the host controller and the tag command handler.
`timescale 1ns/1ns
interface tag_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;
   modport dev (input h2d_data, input h2d_valid, output h2d_ready,
                output d2h_data, output d2h_valid, input d2h_ready);
   modport host (output h2d_data, output h2d_valid, input h2d_ready,
                 input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// ### tb/tag_link_checker.sv
// Concurrent checks on the byte link between the host and device ends.
`timescale 1ns/1ns
module tag_link_checker (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Link signals.
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   // ***************************************************************
   // Frame trackers.
   // ***************************************************************
   logic [7:0] hp_r, hl_r, hs_r, dp_r, dl_r, ds_r;
   logic [7:0] h_last, d_last;
   logic ht, dt, he, de, bz_r;
   assign ht = h2d_valid && h2d_ready;
   assign dt = d2h_valid && d2h_ready;
   assign h_last = hl_r + 8'h03;
   // Error frames always carry two body bytes.
   assign d_last = (dl_r <= 8'h02) ? 8'h05 : dl_r + 8'h03;
   assign he = hp_r == h_last && hp_r > 8'h02;
   assign de = dp_r == d_last && dp_r > 8'h02;
   // Per-direction position, length and sum, plus a response-due flag.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hp_r <= 8'h00;
         dp_r <= 8'h00;
         bz_r <= 1'b0;
      end else begin
         if (ht) begin
            hp_r <= he ? 8'h00 : hp_r + 8'h01;
            hs_r <= (hp_r == 8'h02) ? h2d_data : hs_r + h2d_data;
            hl_r <= (hp_r == 8'h02) ? h2d_data : hl_r;
         end
         if (dt) begin
            dp_r <= de ? 8'h00 : dp_r + 8'h01;
            ds_r <= (dp_r == 8'h02) ? d2h_data : ds_r + d2h_data;
            dl_r <= (dp_r == 8'h02) ? d2h_data : dl_r;
         end
         bz_r <= (ht && he) ? 1'b1 : ((dt && de) ? 1'b0 : bz_r);
      end
   end
   // ***************************************************************
   // Assertions.
   // ***************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence h_take;
      ht;
   endsequence
   sequence d_take;
      dt;
   endsequence
   host_hold_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
      else $error("host byte dropped");
   dev_hold_a: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
      else $error("device byte dropped");
   host_sync_a: assert property (h_take ##0 hp_r == 8'h00 |-> h2d_data == 8'hff)
      else $error("host sync 0 bad");
   host_zero_a: assert property (h_take ##0 hp_r == 8'h01 |-> h2d_data == 8'h00)
      else $error("host sync 1 bad");
   host_sum_a: assert property (h_take ##0 he |-> h2d_data == hs_r)
      else $error("host sum bad");
   dev_sync_a: assert property (d_take ##0 dp_r == 8'h00 |-> d2h_data == 8'hff)
      else $error("device sync 0 bad");
   dev_zero_a: assert property (d_take ##0 dp_r == 8'h01 |-> d2h_data == 8'h00)
      else $error("device sync 1 bad");
   dev_sum_a: assert property (d_take ##0 de |-> d2h_data == ds_r)
      else $error("device sum bad");
   one_cmd_a: assert property (bz_r |-> !h2d_valid)
      else $error("host sent too early");
endmodule // tag_link_checker

// ### tb/testbench.sv
// Self-checking bench joining host and device ends, with a behavioural tag.
`timescale 1ns/1ns
module testbench;
   import tag_cmd_pkg::*;
   // ***************************************************************
   // Signals, instances and tag model.
   // ***************************************************************
   logic clock_i = 1'b0, srst_i = 1'b1, cmd_valid_i = 1'b0, auth_valid_i = 1'b1;
   logic page_tag_i = 1'b0, tag_ack_i = 1'b0, tag_absent_i = 1'b0, tag_fail_i = 1'b0;
   logic [7:0] cmd_op_i = 8'h00, cmd_blk_i = 8'h00, auth_blk_i = 8'h00;
   logic [127:0] cmd_data_i = '0, tag_rdata_i = '0;
   logic cmd_ready_o, rsp_valid_o, rsp_err_o, rsp_chk_bad_o, tag_req_o, tag_we_o;
   logic [7:0] rsp_op_o, rsp_code_o, tag_blk_o;
   logic [127:0] rsp_data_o, tag_wdata_o;
   logic [127:0] mem [0:255];
   localparam logic [127:0] PAT = 128'h0f0e0d0c0b0a09080706050403020100;
   int mode = 0, bad_count = 0, n_compared = 0, cycles = 0;
   tag_link_if tag_link_if_inst ();
   tag_cmd_host tag_cmd_host_inst (.link(tag_link_if_inst), .*);
   tag_cmd_device tag_cmd_device_inst (.link(tag_link_if_inst), .*);
   tag_link_checker tag_link_checker_inst (.clock_i, .srst_i,
      .h2d_data(tag_link_if_inst.h2d_data), .h2d_valid(tag_link_if_inst.h2d_valid),
      .h2d_ready(tag_link_if_inst.h2d_ready), .d2h_data(tag_link_if_inst.d2h_data),
      .d2h_valid(tag_link_if_inst.d2h_valid), .d2h_ready(tag_link_if_inst.d2h_ready));
   always #4 clock_i = ~clock_i;
   // Tag answers a cycle after request: mode 1 no tag, 2 all fail, 3 reads fail, 4 bit 0 flips.
   always @(negedge clock_i) begin
      if (tag_req_o && !tag_ack_i) begin
         if (tag_we_o && mode != 1 && mode != 2) mem[tag_blk_o] = tag_wdata_o;
         tag_absent_i <= (mode == 1);
         tag_fail_i <= (mode == 2) || (mode == 3 && !tag_we_o);
         tag_rdata_i <= mem[tag_blk_o] ^ 128'(mode == 4);
         tag_ack_i <= 1'b1;
      end else begin
         tag_ack_i <= 1'b0;
      end
   end
   // A hang counts as a failure; the whole run needs under a thousand cycles.
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ***************************************************************
   // Tasks and scenarios.
   // ***************************************************************
   function automatic logic [127:0] vb(input logic [31:0] v, input logic [7:0] a);
      return {~a, a, ~a, a, v, ~v, v};
   endfunction
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sends one command in tag mode m, waits for its response and judges it.
   task automatic run(input int m, input logic [7:0] op, input logic [7:0] blk,
                      input logic [127:0] d, input logic [7:0] code, input logic [127:0] exp = '0);
      logic err;
      mode = m;
      err = code inside {ERR_NO_TAG, ERR_FAIL, ERR_VALUE, ERR_MISMATCH, ERR_NO_READ};
      @(negedge clock_i);
      cmd_op_i = op;
      cmd_blk_i = blk;
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      @(negedge clock_i);
      cmd_valid_i = 1'b0;
      for (int i = 0; i < 600 && rsp_valid_o !== 1'b1; i++) @(negedge clock_i);
      check({rsp_valid_o, rsp_chk_bad_o, rsp_err_o, rsp_op_o, rsp_code_o}, {2'b10, err, op, code});
      if (!err) check(rsp_data_o, exp);
   endtask
   task automatic read_case();
      mem[6] = PAT;
      auth_blk_i = 8'h06;
      run(0, OP_RD_BLOCK, 8'h06, '0, 8'h06, PAT);
      run(1, OP_RD_BLOCK, 8'h06, '0, ERR_NO_TAG);
      run(2, OP_RD_BLOCK, 8'h06, '0, ERR_FAIL);
      auth_blk_i = 8'h07;
      run(0, OP_RD_BLOCK, 8'h06, '0, ERR_FAIL);
   endtask
   task automatic page_case();
      for (int p = 0; p < 4; p++) mem[8 + p] = {{3{32'h5a5a5a5a}}, 8'(p), 24'habcdef};
      // A fresh session stands in for reselecting the tag after the refusal.
      auth_blk_i = 8'h08;
      page_tag_i = 1'b1;
      run(0, OP_RD_BLOCK, 8'h08, '0, 8'h08, 128'h03abcdef02abcdef01abcdef00abcdef);
      page_tag_i = 1'b0;
   endtask
   task automatic value_case();
      mem[8] = vb(32'h00002710, 8'h08);
      run(0, OP_RD_VALUE, 8'h08, '0, 8'h08, 128'h2710);
      mem[8][40] = ~mem[8][40];
      run(0, OP_RD_VALUE, 8'h08, '0, ERR_VALUE);
      run(1, OP_RD_VALUE, 8'h08, '0, ERR_NO_TAG);
   endtask
   task automatic wblock_case();
      auth_blk_i = 8'h0a;
      run(0, OP_WR_BLOCK, 8'h0a, PAT, 8'h0a, PAT);
      check(mem[10], PAT);
      run(4, OP_WR_BLOCK, 8'h0a, PAT, ERR_MISMATCH);
      run(3, OP_WR_BLOCK, 8'h0a, PAT, ERR_NO_READ);
      run(2, OP_WR_BLOCK, 8'h0a, PAT, ERR_FAIL);
      run(1, OP_WR_BLOCK, 8'h0a, PAT, ERR_NO_TAG);
   endtask
   task automatic wvalue_case();
      auth_blk_i = 8'h08;
      run(0, OP_WR_VALUE, 8'h08, 128'hfffffc18, 8'h08, 128'hfffffc18);
      check(mem[8], vb(32'hfffffc18, 8'h08));
      run(4, OP_WR_VALUE, 8'h08, 128'h5, ERR_VALUE);
      run(3, OP_WR_VALUE, 8'h08, 128'h5, ERR_FAIL);
      auth_blk_i = 8'h09;
      run(0, OP_WR_VALUE, 8'h08, 128'h5, ERR_FAIL);
   endtask
   task automatic wpage_case();
      auth_valid_i = 1'b0;
      run(0, OP_WR_PAGE, 8'h04, 128'hddccbbaa, 8'h04, 128'hddccbbaa);
      run(4, OP_WR_PAGE, 8'h04, 128'h1, ERR_MISMATCH);
      run(1, OP_WR_PAGE, 8'h04, 128'h1, ERR_NO_TAG);
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence: reset for eight cycles, then every scenario in turn.
   initial begin
      repeat (8) @(negedge clock_i);
      srst_i = 1'b0;
      read_case();
      page_case();
      value_case();
      wblock_case();
      wvalue_case();
      wpage_case();
      report_and_stop();
   end
endmodule // testbench
